// ==== hw/dpsrc_params.svh ====
// constants for the dual-port strap and reset configuration block
`ifndef DPSRC_PARAMS_SVH
`define DPSRC_PARAMS_SVH

`define DPSRC_SLEW_W        2
`define DPSRC_BASE_W        4
`define DPSRC_ADDR_W        5
`define DPSRC_SLEW_RST      2'h0
`define DPSRC_BASE_RST      4'h0
`define DPSRC_PORT0_LSB     1'h0
`define DPSRC_PORT1_LSB     1'h1
`define DPSRC_REG27_SLEW_HI 11
`define DPSRC_REG27_SLEW_LO 10
`define DPSRC_REG0_SWRST    15

`endif

// ==== hw/dpsrc_pkg.sv ====
// types shared by the strap and reset configuration block
package dpsrc_pkg;
  typedef struct packed {
    logic [1:0] slew;
    logic [3:0] base_addr;
    logic       mgmt_disable;
  } dpsrc_strap_t;

  typedef struct packed {
    logic [4:0] port0_addr;
    logic [4:0] port1_addr;
  } dpsrc_addr_t;

  typedef enum logic [1:0] {
    DPSRC_IN_RESET,
    DPSRC_SAMPLE,
    DPSRC_RUN
  } dpsrc_state_t;
endpackage

// ==== hw/dpsrc_sync2.sv ====
// two-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none
module dpsrc_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

// ==== hw/dpsrc_top.sv ====
// strap capture, address derivation and reset combining for both ports
//
// Functional notes
// - two slew straps load register 27 bits 11:10 at power-on, shared by both ports
// - four address straps form bits 4:1 of port 0 address
// - address bit 0 internal; port 1 address is port 0 plus one
// - in fiber mode each port uses its own signal-detect input
// - management-disable low: straps set defaults only, management owns bits after reset
`timescale 1ns/1ns
`default_nettype none
`include "dpsrc_params.svh"
module dpsrc_top (
  // clock and pin reset
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  // software reset, control bit 0.15
  input  wire logic                      sw_reset,
  // strap pins
  input  wire logic                      slew_sel_strap_lo,
  input  wire logic                      slew_sel_strap_hi,
  input  wire logic                      base_addr_strap_b4,
  input  wire logic                      base_addr_strap_b3,
  input  wire logic                      base_addr_strap_b2,
  input  wire logic                      base_addr_strap_b1,
  input  wire logic                      mgmt_disable_strap,
  input  wire logic [1:0]                test_mode,
  // management writes to register 27 slew field
  input  wire logic                      mgmt_slew_we,
  input  wire logic [`DPSRC_SLEW_W-1:0]  mgmt_slew_wdata,
  // per-port medium selection and signal detect
  input  wire logic                      fiber_mode_p0,
  input  wire logic                      fiber_mode_p1,
  input  wire logic                      fiber_sig_detect_p0,
  input  wire logic                      fiber_sig_detect_p1,
  // results
  output logic                           core_reset_b,
  output logic [`DPSRC_SLEW_W-1:0]       slew_sel,
  output logic [`DPSRC_ADDR_W-1:0]       port0_addr,
  output logic [`DPSRC_ADDR_W-1:0]       port1_addr,
  output logic                           mgmt_port_enable,
  output logic                           sig_ok_p0,
  output logic                           sig_ok_p1,
  output logic                           test_mode_active
);
  logic                  rst_meta_reg;
  logic                  rst_sync_reg;
  logic                  rst_meta_next;
  logic                  rst_sync_next;
  logic                  sys_rst_b;
  logic [10:0]           pins_sync;
  logic [1:0]            test_sync;
  dpsrc_pkg::dpsrc_strap_t strap_now;
  dpsrc_pkg::dpsrc_strap_t strap_reg;
  dpsrc_pkg::dpsrc_strap_t strap_next;
  dpsrc_pkg::dpsrc_state_t state_reg;
  dpsrc_pkg::dpsrc_state_t state_next;
  logic [`DPSRC_SLEW_W-1:0] slew_reg;
  logic [`DPSRC_SLEW_W-1:0] slew_next;
  dpsrc_pkg::dpsrc_addr_t   addr_reg;
  dpsrc_pkg::dpsrc_addr_t   addr_next;
  logic [1:0]               sig_reg;
  logic [1:0]               sig_next;

  // combined reset: pin or software bit; pin reset release passes through two flops
  always_comb
  begin
    rst_meta_next = 1'b1;
    rst_sync_next = rst_meta_reg;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= rst_meta_next;
      rst_sync_reg <= rst_sync_next;
    end
  end

  // sw_reset comes from same-clock register logic, so no synchroniser
  assign sys_rst_b    = rst_sync_reg & ~sw_reset;
  assign core_reset_b = sys_rst_b;

  // all strap and detect pins are asynchronous board levels
  dpsrc_sync2 #(
    .WIDTH (11)
  ) u_pin_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in ({slew_sel_strap_hi, slew_sel_strap_lo,
                base_addr_strap_b4, base_addr_strap_b3,
                base_addr_strap_b2, base_addr_strap_b1,
                mgmt_disable_strap, fiber_sig_detect_p1,
                fiber_sig_detect_p0, test_mode}),
    .sync_out (pins_sync)
  );

  assign test_sync              = pins_sync[1:0];
  assign strap_now.slew         = pins_sync[10:9];
  assign strap_now.base_addr    = pins_sync[8:5];
  assign strap_now.mgmt_disable = pins_sync[4];

  // sample straps one cycle after reset release, once synchronised values settle
  always_comb
  begin
    state_next = state_reg;
    strap_next = strap_reg;
    case (state_reg)
      dpsrc_pkg::DPSRC_IN_RESET:
        state_next = dpsrc_pkg::DPSRC_SAMPLE;
      dpsrc_pkg::DPSRC_SAMPLE:
      begin
        strap_next = strap_now;
        state_next = dpsrc_pkg::DPSRC_RUN;
      end
      dpsrc_pkg::DPSRC_RUN:
        state_next = dpsrc_pkg::DPSRC_RUN;
      default:
        state_next = dpsrc_pkg::DPSRC_IN_RESET;
    endcase
  end

  always_ff @(posedge clock or negedge sys_rst_b)
  begin
    if (!sys_rst_b)
    begin
      state_reg <= dpsrc_pkg::DPSRC_IN_RESET;
      strap_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      strap_reg <= strap_next;
    end
  end

  // register 27 slew field: strap gives the power-on value,
  // management may overwrite it unless the management port is disabled
  always_comb
  begin
    slew_next = slew_reg;
    if (state_reg == dpsrc_pkg::DPSRC_SAMPLE)
    begin
      slew_next = strap_now.slew;
    end
    else if (state_reg == dpsrc_pkg::DPSRC_RUN && mgmt_slew_we && !strap_reg.mgmt_disable)
    begin
      slew_next = mgmt_slew_wdata;
    end
  end

  always_ff @(posedge clock or negedge sys_rst_b)
  begin
    if (!sys_rst_b)
    begin
      slew_reg <= `DPSRC_SLEW_RST;
    end
    else
    begin
      slew_reg <= slew_next;
    end
  end

  // one slew setting drives both port cores
  assign slew_sel = slew_reg;

  // port addresses from the held base strap
  always_comb
  begin
    addr_next.port0_addr = {strap_reg.base_addr, `DPSRC_PORT0_LSB};
    addr_next.port1_addr = {strap_reg.base_addr, `DPSRC_PORT1_LSB};
  end

  always_ff @(posedge clock or negedge sys_rst_b)
  begin
    if (!sys_rst_b)
    begin
      addr_reg <= '0;
    end
    else
    begin
      addr_reg <= addr_next;
    end
  end

  assign port0_addr = addr_reg.port0_addr;
  assign port1_addr = addr_reg.port1_addr;

  // management port lives only once straps are held and it is not disabled
  assign mgmt_port_enable = (state_reg == dpsrc_pkg::DPSRC_RUN) & ~strap_reg.mgmt_disable;

  // signal quality: own detect in fiber mode; in twisted-pair the pin is grounded
  always_comb
  begin
    sig_next[0] = fiber_mode_p0 & pins_sync[2];
    sig_next[1] = fiber_mode_p1 & pins_sync[3];
  end

  always_ff @(posedge clock or negedge sys_rst_b)
  begin
    if (!sys_rst_b)
    begin
      sig_reg <= 2'h0;
    end
    else
    begin
      sig_reg <= sig_next;
    end
  end

  assign sig_ok_p0 = sig_reg[0];
  assign sig_ok_p1 = sig_reg[1];

  // flags a board that violates the low tie on the test inputs
  assign test_mode_active = |test_sync;
endmodule
`default_nettype wire

// ==== dv/dpsrc_props.sv ====
// assertion checker for the strap and reset block
`timescale 1ns/1ns
`default_nettype none
module dpsrc_props (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_b,
  // watched ports
  input wire logic       sw_reset,
  input wire logic       mgmt_slew_we,
  input wire logic [1:0] mgmt_slew_wdata,
  input wire logic       fiber_mode_p0,
  input wire logic       fiber_mode_p1,
  input wire logic       fiber_sig_detect_p1,
  input wire logic       core_reset_b,
  input wire logic [1:0] slew_sel,
  input wire logic [4:0] port0_addr,
  input wire logic [4:0] port1_addr,
  input wire logic       mgmt_port_enable,
  input wire logic       sig_ok_p0,
  input wire logic       sig_ok_p1
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_p0_lsb;
    port0_addr[0] == 1'h0;
  endproperty
  a_p0_lsb: assert property (p_p0_lsb) else $error("port 0 lsb set");
  property p_p1_addr;
    mgmt_port_enable |-> port1_addr == {port0_addr[4:1], 1'h1};
  endproperty
  a_p1_addr: assert property (p_p1_addr) else $error("port 1 address");
  property p_sw_reset;
    sw_reset |-> !core_reset_b && slew_sel == 2'h0;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("soft reset");
  property p_addr_hold;
    // addresses settle one cycle after the straps are held
    mgmt_port_enable && $past(mgmt_port_enable) && $past(mgmt_port_enable, 2) |->
      $stable(port0_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_slew_write;
    mgmt_port_enable && mgmt_slew_we && !sw_reset |=>
      sw_reset || slew_sel == $past(mgmt_slew_wdata);
  endproperty
  a_slew_write: assert property (p_slew_write) else $error("slew write");
  property p_slew_hold;
    mgmt_port_enable && $past(mgmt_port_enable) && !$past(mgmt_slew_we) |-> $stable(slew_sel);
  endproperty
  a_slew_hold: assert property (p_slew_hold) else $error("slew moved");
  property p_fiber_off;
    !fiber_mode_p0 |=> !sig_ok_p0;
  endproperty
  a_fiber_off: assert property (p_fiber_off) else $error("detect in copper");
  property p_fiber_on;
    (fiber_mode_p1 && fiber_sig_detect_p1 && core_reset_b) [*4] |-> sig_ok_p1;
  endproperty
  a_fiber_on: assert property (p_fiber_on) else $error("detect lost");
  c_write: cover property (mgmt_port_enable && mgmt_slew_we);
  c_soft: cover property (sw_reset);
  c_fiber: cover property (sig_ok_p1);
endmodule
bind dpsrc_top dpsrc_props u_props (.clock(clock), .rst_b(rst_b), .sw_reset(sw_reset),
  .mgmt_slew_we(mgmt_slew_we), .mgmt_slew_wdata(mgmt_slew_wdata),
  .fiber_mode_p0(fiber_mode_p0), .fiber_mode_p1(fiber_mode_p1),
  .fiber_sig_detect_p1(fiber_sig_detect_p1), .core_reset_b(core_reset_b),
  .slew_sel(slew_sel), .port0_addr(port0_addr), .port1_addr(port1_addr),
  .mgmt_port_enable(mgmt_port_enable), .sig_ok_p0(sig_ok_p0), .sig_ok_p1(sig_ok_p1));
`default_nettype wire

// ==== dv/dpsrc_board.sv ====
// board wiring model: strap pins, test ties and signal-detect ties
`timescale 1ns/1ns
`default_nettype none
module dpsrc_board (
  // wanted settings
  input  wire dpsrc_pkg::dpsrc_strap_t strap,
  input  wire logic [1:0]              fiber,
  input  wire logic [1:0]              light,
  // pins
  output var dpsrc_pkg::dpsrc_strap_t  pins,
  output logic [1:0]                   test_mode,
  output logic [1:0]                   sig_detect
);
  assign pins       = strap;
  assign test_mode  = 2'h0;
  // copper ports have detect grounded
  assign sig_detect = fiber & light;
endmodule
`default_nettype wire

// ==== dv/dpsrc_top_tb.sv ====
// self-checking bench for the strap and reset block
`timescale 1ns/1ns
`default_nettype none
module dpsrc_top_tb;
  logic                    clock = 1'h0;
  logic                    rst_b = 1'h0;
  logic                    sw_reset = 1'h0;
  logic                    we = 1'h0;
  logic [1:0]              wdata = 2'h0;
  logic [1:0]              fiber = 2'h0;
  logic [1:0]              light = 2'h0;
  dpsrc_pkg::dpsrc_strap_t strap = '0;
  dpsrc_pkg::dpsrc_strap_t pins;
  logic [1:0]              tm, sd, slew;
  logic [4:0]              a0, a1;
  logic                    crb, mpe, ok0, ok1, tma;
  int                      miscompares = 0;
  int                      checks_done = 0;
  always #50 clock = ~clock;
  dpsrc_board board (.strap(strap), .fiber(fiber), .light(light), .pins(pins),
    .test_mode(tm), .sig_detect(sd));
  dpsrc_top dut (.clock(clock), .rst_b(rst_b), .sw_reset(sw_reset),
    .slew_sel_strap_lo(pins.slew[0]), .slew_sel_strap_hi(pins.slew[1]),
    .base_addr_strap_b4(pins.base_addr[3]), .base_addr_strap_b3(pins.base_addr[2]),
    .base_addr_strap_b2(pins.base_addr[1]), .base_addr_strap_b1(pins.base_addr[0]),
    .mgmt_disable_strap(pins.mgmt_disable), .test_mode(tm), .mgmt_slew_we(we),
    .mgmt_slew_wdata(wdata), .fiber_mode_p0(fiber[0]), .fiber_mode_p1(fiber[1]),
    .fiber_sig_detect_p0(sd[0]), .fiber_sig_detect_p1(sd[1]), .core_reset_b(crb),
    .slew_sel(slew), .port0_addr(a0), .port1_addr(a1), .mgmt_port_enable(mpe),
    .sig_ok_p0(ok0), .sig_ok_p1(ok1), .test_mode_active(tma));
  task automatic chk(input logic [4:0] seen, input logic [4:0] exp, input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // one management write; back-to-back calls keep the strobe up
  task automatic write_slew(input logic [1:0] d);
    we = 1'h1;
    wdata = d;
    cyc(1);
  endtask
  task automatic results;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // pin reset, then bounded wait for release plus capture
  task automatic boot;
    int i;
    rst_b = 1'h0;
    cyc(12);
    rst_b = 1'h1;
    for (i = 0; i < 10 && crb !== 1'h1; i++) cyc(1);
    if (i == 10)
    begin
      miscompares++;
      results();
    end
    cyc(4);
  endtask
  initial
  begin
    strap = '{slew: 2'h3, base_addr: 4'hf, mgmt_disable: 1'h0};
    boot();
    chk(a0, 5'h1e, "port 0 address");
    chk(a1, 5'h1f, "port 1 address");
    chk({3'h0, slew}, 5'h03, "slew strap");
    chk({4'h0, mpe}, 5'h01, "mgmt enabled");
    strap = '{slew: 2'h1, base_addr: 4'h3, mgmt_disable: 1'h0};
    cyc(5);
    chk(a0, 5'h1e, "address held");
    chk({3'h0, slew}, 5'h03, "slew held");
    $display("test strap capture done");
    write_slew(2'h1);
    write_slew(2'h2);
    we = 1'h0;
    cyc(1);
    chk({3'h0, slew}, 5'h02, "slew write");
    sw_reset = 1'h1;
    cyc(1);
    chk({4'h0, crb}, 5'h00, "soft reset");
    chk({3'h0, slew}, 5'h00, "soft reset slew");
    sw_reset = 1'h0;
    cyc(8);
    chk(a1, 5'h07, "resampled port 1");
    chk(a0, 5'h06, "resampled port 0");
    chk({3'h0, slew}, 5'h01, "resampled slew");
    $display("test soft reset done");
    strap = '{slew: 2'h2, base_addr: 4'h5, mgmt_disable: 1'h1};
    boot();
    write_slew(2'h1);
    we = 1'h0;
    cyc(1);
    chk({3'h0, slew}, 5'h02, "refused write");
    chk({4'h0, mpe}, 5'h00, "mgmt disabled");
    chk(a0, 5'h0a, "port 0 address");
    $display("test mgmt disable done");
    fiber = 2'h1;
    light = 2'h3;
    cyc(4);
    chk({3'h0, ok1, ok0}, 5'h01, "fiber port 0");
    fiber = 2'h2;
    cyc(4);
    chk({3'h0, ok1, ok0}, 5'h02, "fiber port 1");
    light = 2'h1;
    cyc(4);
    chk({3'h0, ok1, ok0}, 5'h00, "fiber port 1 dark");
    chk({4'h0, tma}, 5'h00, "test pins");
    $display("test fiber done");
    results();
  end
endmodule
`default_nettype wire
